// *** rtl/flash_cpu_access_interface.sv ***
// Purpose: Classic Wishbone slave between the CPU bus and the flash macro.
// Assumes: Macro read data is valid while the request is held; same clock.
// Notes:   Rejected accesses end with ack and zero data, flagged in status.
// Notes on behaviour
// - Widest mode reads 64-bit, refuses all array writes
// - Widest mode returns requested word of dword
// - 32-bit mode: word fetches, word array access
// - 16-bit mode: half-words only, no fetches
// - 16-bit mode: array access sixteen bits wide
// - Separate programmable read and write waits
// - Small 64K: halve offset, odd adds 0x10000
// - Large 8K: halve, subtract, odd adds 0x2000
// - Large 64K: halve, add 0x0C0000, odd more
// - Small variant: macro address bit 20 high
// - Large variant: macro address bit 21 high
// - Security vector bytes refuse CPU writes
// - Array capacity set by sector counts
module flash_cpu_access_interface
   import flash_pkg::*;
#(
   parameter bit LARGE = 1'b1
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic        ifetch_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Flash macro
   output macro_req_t       macro_req_o,
   input  wire logic [63:0] macro_rdata_i
);
   // 8K base and 64K top derived from the array capacity
   localparam int N8 = LARGE ? SEC8_LARGE : SEC8_SMALL;
   localparam int N64 = LARGE ? SEC64_LARGE : SEC64_SMALL;
   localparam logic [23:0] LO_8K = REGION_END - SIZE_8K * N8[23:0];
   localparam logic [23:0] LO_64K = LARGE ? LO_64K_LARGE : LO_64K_SMALL;
   // Top of the 64K region follows the sector count, so the smaller array
   // ends early and nothing maps past its last sector
   localparam logic [23:0] END_64K = LO_64K + ODD_64K * N64[23:0] - 24'h000001;
   localparam logic [23:0] PROG_OFS = LARGE ? PROG_OFS_LARGE : PROG_OFS_SMALL;

   // Access state machine
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_DONE = 2'b11
   } state_t;

   state_t       state_r;        // Current bus phase
   logic [4:0]   cnt_r;          // Remaining wait cycles
   logic         ack_r;          // Acknowledge flop
   logic [31:0]  dat_r;          // Read data flop
   macro_req_t   req_r;          // Macro request flop
   access_mode_t mode_r;         // Selected access mode
   logic [7:0]   rd_tim_r;       // Read timing fields
   logic [7:0]   wr_tim_r;       // Write timing fields
   logic [2:0]   flags_r;        // Sticky refusal flags
   logic [2:0]   flags_nxt;      // Next value of the flags

   logic [23:0]  a;              // Significant address bits
   logic         in_8k;          // Address in 8K sector region
   logic         in_flash;       // Address in flash space
   logic         in_regs;        // Address in control block
   logic         sec_vec;        // Address hits security vectors
   logic         take;           // Request taken this cycle
   logic         rej_wr;         // Write refused
   logic         rej_fetch;      // Fetch refused
   logic         rej_size;       // Access size refused
   logic         flash_ok;       // Flash access starts
   logic [4:0]   rd_waits;       // Total read wait cycles
   logic [4:0]   wr_waits;       // Total write wait cycles
   logic [21:0]  mapped;         // Macro address of this request
   logic [31:0]  reg_rdata;      // Register read mux
   logic [31:0]  lane_rdata;     // Macro data on the bus lanes

   // Address decode
   assign a        = wb_adr_i[23:0];
   assign in_8k    = wb_adr_i[31:24] == 8'h00 && a >= LO_8K && a < REGION_END;
   assign in_flash = in_8k || (wb_adr_i[31:24] == 8'h00 && a >= LO_64K && a <= END_64K);
   assign in_regs  = wb_adr_i[31:4] == REG_BASE[31:4];
   assign sec_vec  = in_8k && a >= SEC_VEC_LO && a <= SEC_VEC_HI;
   assign take     = state_r == ST_IDLE && wb_cyc_i && wb_stb_i;

   // Refusal checks per access mode
   always_comb begin
      rej_wr    = wb_we_i && (mode_r == MODE_64 || sec_vec);
      rej_fetch = ifetch_i && mode_r == MODE_16;
      if (mode_r == MODE_16) begin
         rej_size = !(wb_sel_i == 4'hC || wb_sel_i == 4'h3);
      end else begin
         rej_size = wb_we_i && wb_sel_i != 4'hF;
      end
   end

   // Only an accepted flash access opens a wait phase
   assign flash_ok = take && in_flash && !rej_wr && !rej_fetch && !rej_size;

   // Wait totals from the timing fields
   // Reads add the equalize cycles; writes have no such field
   assign rd_waits = 5'(rd_tim_r[7:4]) + 5'(rd_tim_r[0]) + 5'(rd_tim_r[1])
                   + 5'(rd_tim_r[3:2]);
   assign wr_waits = 5'(wr_tim_r[7:4]) + 5'(wr_tim_r[0]) + 5'(wr_tim_r[1]);

   // CPU address to macro address
   // Halving the block offset interleaves sector pairs; address bit 2
   // picks the odd sector, whose half starts half a block further on
   function automatic logic [21:0] map_addr(input logic [23:0] ad, input logic small_sec,
                                           input logic wide);
      logic [23:0] blk;
      logic [23:0] off;
      logic [23:0] fa;
      logic        odd;
      blk = small_sec ? BLK_8K : BLK_64K;
      off = ad & (blk - 24'h000001);
      odd = ad[2] && !wide;                          // Dword fetch starts even
      fa  = ad - off + {3'h0, off[23:3]} * 24'h000004 + {22'h0, ad[1:0]};
      if (odd) begin
         fa = fa + (small_sec ? ODD_8K : ODD_64K);
      end
      if (small_sec) begin
         fa = fa - (LARGE ? SUB_8K_LARGE : SUB_8K_SMALL);
      end else if (LARGE) begin
         fa = fa + ADD_64K_LARGE;
      end
      fa = fa + PROG_OFS;
      if (wide) begin
         fa[2:0] = 3'h0;
      end
      return fa[21:0];
   endfunction

   assign mapped = map_addr(a, in_8k, mode_r == MODE_64);

   // Register read mux
   always_comb begin
      case (wb_adr_i[3:0])
         OFS_MODE:      reg_rdata = {30'h0, mode_r};
         OFS_RD_TIMING: reg_rdata = {24'h0, rd_tim_r};
         OFS_WR_TIMING: reg_rdata = {24'h0, wr_tim_r};
         OFS_STATUS:    reg_rdata = {28'h0, flags_r, state_r != ST_IDLE};
         default:       reg_rdata = 32'h0;
      endcase
   end

   // Macro data placed on the requested lanes
   always_comb begin
      case (req_r.width)
         MODE_64: lane_rdata = wb_adr_i[2] ? macro_rdata_i[31:0]
                                           : macro_rdata_i[63:32];
         MODE_16: lane_rdata = wb_adr_i[1] ? {16'h0, macro_rdata_i[15:0]}
                                           : {macro_rdata_i[15:0], 16'h0};
         default: lane_rdata = macro_rdata_i[31:0];
      endcase
   end

   // Bus phase sequencing and wait counting
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
         cnt_r   <= 5'h00;
         ack_r   <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (flash_ok) begin
                  state_r <= ST_WAIT;
                  cnt_r   <= wb_we_i ? wr_waits : rd_waits;
               end else if (take) begin
                  state_r <= ST_DONE;
                  ack_r   <= 1'b1;
               end
            end
            ST_WAIT: begin
               if (cnt_r == 5'h00) begin
                  state_r <= ST_DONE;
                  ack_r   <= 1'b1;
               end else begin
                  cnt_r <= cnt_r - 5'h01;
               end
            end
            ST_DONE: begin
               // Ack stands one cycle while the master drops its strobe
               state_r <= ST_IDLE;
               ack_r   <= 1'b0;
            end
            default: begin
               state_r <= ST_IDLE;
               ack_r   <= 1'b0;
            end
         endcase
      end
   end

   // Macro request issue and release
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_r <= '{addr: 22'h0, rd: 1'b0, wr: 1'b0, width: MODE_RESET, wdata: 32'h0};
      end else if (flash_ok) begin
         req_r.addr  <= mapped;
         req_r.rd    <= !wb_we_i;
         req_r.wr    <= wb_we_i;
         req_r.width <= mode_r;
         if (mode_r == MODE_16) begin
            req_r.wdata <= {16'h0, wb_adr_i[1] ? wb_dat_i[15:0] : wb_dat_i[31:16]};
         end else begin
            req_r.wdata <= wb_dat_i;
         end
      end else if (state_r == ST_WAIT && cnt_r == 5'h00) begin
         req_r.rd <= 1'b0;
         req_r.wr <= 1'b0;
      end
   end

   // Read data capture
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_r <= 32'h0;
      end else if (take && in_regs && !wb_we_i) begin
         dat_r <= reg_rdata;
      end else if (take) begin
         dat_r <= 32'h0;                                      // Flash start, register write, refused or unmapped
      end else if (state_r == ST_WAIT && cnt_r == 5'h00 && req_r.rd) begin
         dat_r <= lane_rdata;
      end
   end

   // Mode register; widest mode only on the larger variant
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_r <= MODE_RESET;
      end else if (take && in_regs && wb_we_i && wb_sel_i[0] && wb_adr_i[3:0] == OFS_MODE) begin
         if (wb_dat_i[1:0] == MODE_16) begin
            mode_r <= MODE_16;
         end else if (wb_dat_i[1:0] == MODE_64 && LARGE) begin
            mode_r <= MODE_64;
         end else begin
            mode_r <= MODE_32;
         end
      end
   end

   // Timing registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_tim_r <= RD_TIM_RESET;
         wr_tim_r <= WR_TIM_RESET;
      end else if (take && in_regs && wb_we_i && wb_sel_i[0]) begin
         if (wb_adr_i[3:0] == OFS_RD_TIMING) begin
            rd_tim_r <= wb_dat_i[7:0];
         end
         if (wb_adr_i[3:0] == OFS_WR_TIMING) begin
            wr_tim_r <= {wb_dat_i[7:4], 2'h0, wb_dat_i[1:0]};
         end
      end
   end

   // Sticky refusal flags; a new refusal beats a clear
   always_comb begin
      flags_nxt = flags_r;
      if (take && in_regs && wb_we_i && wb_sel_i[0] && wb_adr_i[3:0] == OFS_STATUS) begin
         flags_nxt = flags_r & ~wb_dat_i[3:1];
      end
      if (take && in_flash) begin
         flags_nxt = flags_nxt | {rej_size, rej_fetch, rej_wr};
      end
   end

   // Flag register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_r <= 3'h0;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // Outputs straight from flops
   assign wb_ack_o    = ack_r;
   assign wb_dat_o    = dat_r;
   assign macro_req_o = req_r;

   // Helper: cycles spent waiting and the count loaded
   logic [5:0] lat_r;
   logic [4:0] load_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lat_r  <= 6'h00;
         load_r <= 5'h00;
      end else if (flash_ok) begin
         lat_r  <= 6'h00;
         load_r <= wb_we_i ? wr_waits : rd_waits;
      end else if (state_r == ST_WAIT) begin
         lat_r <= lat_r + 6'h01;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Each check below guards the rule named by its tag
   wide_no_write_a: assert property (req_r.wr |-> req_r.width != MODE_64)
      else $error("write issued in widest mode");
   wide_dword_a: assert property (req_r.rd && req_r.width == MODE_64
      |-> req_r.addr[2:0] == 3'h0)
      else $error("dword fetch not aligned");
   word_width_a: assert property (flash_ok && mode_r == MODE_32 |=> req_r.width == MODE_32)
      else $error("word mode access width wrong");
   half_fetch_a: assert property (take && ifetch_i && mode_r == MODE_16
      |=> ack_r && !req_r.rd ##1 !ack_r)
      else $error("fetch served in half-word mode");
   half_size_a: assert property (take && in_flash && mode_r == MODE_16
      && wb_sel_i != 4'hC && wb_sel_i != 4'h3 |=> ack_r && flags_r[2])
      else $error("bad half-word lanes not refused");
   half_width_a: assert property (flash_ok && mode_r == MODE_16 |=> req_r.width == MODE_16)
      else $error("half-word access width wrong");
   wait_count_a: assert property ($rose(ack_r) && $past(state_r) == ST_WAIT
      |-> lat_r == 6'(load_r) + 6'h01)
      else $error("flash wait length wrong");
   flash_ack_a: assert property (flash_ok |=> !ack_r throughout (state_r == ST_WAIT)[*1])
      else $error("ack before waits elapsed");
   ack_pulse_a: assert property (ack_r |=> !ack_r)
      else $error("ack held longer than one cycle");
   req_release_a: assert property ($rose(ack_r) |-> !req_r.rd && !req_r.wr)
      else $error("macro strobe still up at ack");
   sec_vec_a: assert property (take && sec_vec && wb_we_i |=> !req_r.wr && flags_r[0])
      else $error("security vector write not refused");
   prog_bit_a: assert property ((req_r.rd || req_r.wr)
      |-> (LARGE ? req_r.addr[21] : req_r.addr[20]))
      else $error("macro address offset bit low");
   odd_sector_a: assert property (flash_ok && mode_r != MODE_64 && !in_8k && !LARGE
      |=> req_r.addr[16] == $past(a[2]))
      else $error("odd sector selection wrong");
endmodule

// *** rtl/flash_pkg.sv ***
// Purpose: Shared constants and types for the flash CPU access interface.
// Assumes: Byte addresses on the CPU side, 24 significant address bits.
// Notes:   Timing reset values are the slowest documented settings.
package flash_pkg;
   // Access modes of the interface
   typedef enum logic [1:0] {
      MODE_16 = 2'h0,
      MODE_32 = 2'h1,
      MODE_64 = 2'h2
   } access_mode_t;

   // Request towards the flash macro
   typedef struct packed {
      logic [21:0]  addr;
      logic         rd;
      logic         wr;
      access_mode_t width;
      logic [31:0]  wdata;
   } macro_req_t;

   // Array capacity in sectors per variant
   localparam int SEC64_LARGE = 16;
   localparam int SEC8_LARGE  = 8;
   localparam int SEC64_SMALL = 8;
   localparam int SEC8_SMALL  = 4;

   // Address regions of the flash space
   localparam logic [23:0] REGION_END    = 24'h150000;
   localparam logic [23:0] SIZE_8K       = 24'h002000;
   localparam logic [23:0] LO_64K_LARGE  = 24'h040000;
   localparam logic [23:0] LO_64K_SMALL  = 24'h080000;
   localparam logic [23:0] HI_64K        = 24'h13FFFF;
   localparam logic [23:0] SEC_VEC_LO    = 24'h148000;
   localparam logic [23:0] SEC_VEC_HI    = 24'h14800F;

   // Interleave blocks, odd-sector offsets and macro adjustments
   localparam logic [23:0] BLK_8K        = 24'h004000;
   localparam logic [23:0] BLK_64K       = 24'h020000;
   localparam logic [23:0] ODD_8K        = 24'h002000;
   localparam logic [23:0] ODD_64K       = 24'h010000;
   localparam logic [23:0] SUB_8K_SMALL  = 24'h0D0000;
   localparam logic [23:0] SUB_8K_LARGE  = 24'h050000;
   localparam logic [23:0] ADD_64K_LARGE = 24'h0C0000;
   localparam logic [23:0] PROG_OFS_SMALL = 24'h100000;
   localparam logic [23:0] PROG_OFS_LARGE = 24'h200000;

   // Control register block
   localparam logic [31:0] REG_BASE      = 32'h0020_0000;
   localparam logic [3:0]  OFS_MODE      = 4'h0;
   localparam logic [3:0]  OFS_RD_TIMING = 4'h4;
   localparam logic [3:0]  OFS_WR_TIMING = 4'h8;
   localparam logic [3:0]  OFS_STATUS    = 4'hC;

   // Reset values of the control registers
   localparam access_mode_t MODE_RESET   = MODE_32;
   localparam logic [7:0]  RD_TIM_RESET  = 8'h4F;
   localparam logic [7:0]  WR_TIM_RESET  = 8'h83;
endpackage

// *** verification/flash_macro_model.sv ***
// Purpose: Behavioural flash macro array facing the access interface.
// Assumes: Read data follows the held request within the same cycle.
// Notes:   Data is an address pattern; a released bus shows its inverse.
module flash_macro_model
   import flash_pkg::*;
(
   // Clock
   input  wire logic        clk_i,
   // Request from the interface
   input  macro_req_t       req_i,
   // Answer and observation
   output logic      [63:0] rdata_o,
   output logic      [21:0] last_addr_o,
   output logic      [31:0] last_wdata_o,
   output logic      [7:0]  hold_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic        act;    // Array access in progress
   logic        prev_r; // Access seen in the previous cycle
   logic [31:0] pat;    // Word pattern made from the address

   assign act = req_i.rd | req_i.wr;
   assign pat = {8'h3C, 2'h0, req_i.addr};
   // Upper word marked apart; idle bus never repeats valid data
   assign rdata_o = req_i.rd ? {8'hA5, pat[23:0], pat} : ~{8'hA5, pat[23:0], pat};

   // Record address, write data and how long the strobe stands
   always_ff @(posedge clk_i) begin
      prev_r <= act;
      if (act) begin
         hold_o      <= prev_r ? hold_o + 8'h01 : 8'h01;
         last_addr_o <= req_i.addr;
         if (req_i.wr) begin
            last_wdata_o <= req_i.wdata;
         end
      end
   end
endmodule

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench for the flash CPU access interface.
// Assumes: Classic Wishbone master, one transfer at a time.
// Notes:   Both variants are built; a select steers the bus between them.
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top
   import flash_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk_i, rst_i, cyc, stb, we, ifetch, use_small; // Bus controls
   logic [31:0] adr, wdat, dat_l, dat_s, dat_o;                 // Address and data
   logic [3:0]  sel;                                            // Byte enables
   logic        ack_l, ack_s, ack;                              // Answers
   macro_req_t  req_l, req_s;                                   // Macro requests
   logic [63:0] rd_l, rd_s;                                     // Macro read data
   logic [21:0] la_l, la_s, la;                                 // Last macro address
   logic [31:0] lw_l, lw_s, lw;                                 // Last write data
   logic [7:0]  h_l, h_s, hold;                                 // Strobe length
   int          n_errors, n_checks;                             // Verdict counters

   assign ack   = use_small ? ack_s : ack_l;
   assign dat_o = use_small ? dat_s : dat_l;
   assign la    = use_small ? la_s : la_l;
   assign lw    = use_small ? lw_s : lw_l;
   assign hold  = use_small ? h_s : h_l;

   // Larger variant and its array
   flash_cpu_access_interface #(.LARGE(1'b1)) flash_cpu_access_interface_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc & ~use_small), .wb_stb_i(stb & ~use_small),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .ifetch_i(ifetch),
      .wb_dat_o(dat_l), .wb_ack_o(ack_l), .macro_req_o(req_l), .macro_rdata_i(rd_l));
   flash_macro_model flash_macro_model_i (.clk_i(clk_i), .req_i(req_l), .rdata_o(rd_l),
      .last_addr_o(la_l), .last_wdata_o(lw_l), .hold_o(h_l));
   // Smaller variant and its array
   flash_cpu_access_interface #(.LARGE(1'b0)) flash_cpu_access_interface_small_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc & use_small), .wb_stb_i(stb & use_small),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .ifetch_i(ifetch),
      .wb_dat_o(dat_s), .wb_ack_o(ack_s), .macro_req_o(req_s), .macro_rdata_i(rd_s));
   flash_macro_model flash_macro_model_small_i (.clk_i(clk_i), .req_i(req_s), .rdata_o(rd_s),
      .last_addr_o(la_s), .last_wdata_o(lw_s), .hold_o(h_s));

   // 40 MHz clock
   always #12.5 clk_i = ~clk_i;

   // Expected macro address, programming offset included
   function automatic logic [21:0] fa_f(input logic [23:0] a, input bit lg);
      logic [23:0] b;
      logic [23:0] r;
      b = (a >= (lg ? 24'h140000 : 24'h148000)) ? BLK_8K : BLK_64K;
      r = a - a % b + (a % b) / 2 - (a / 2) % 4 + a % 4 + (a[2] ? b / 2 : 24'h0);
      if (b == BLK_8K) begin
         r = r - (lg ? SUB_8K_LARGE : SUB_8K_SMALL);
      end else if (lg) begin
         r = r + ADD_64K_LARGE;
      end
      return 22'(r + (lg ? PROG_OFS_LARGE : PROG_OFS_SMALL));
   endfunction

   // One classic cycle; lat counts edges from launch to ack
   task automatic acc(input logic w, input logic [31:0] a, input logic [3:0] s,
                      input logic [31:0] d, input logic f, output logic [31:0] q,
                      output int lat);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d; ifetch <= f;
      lat = 0;
      do begin
         @(posedge clk_i);
         lat++;
      end while (ack !== 1'b1); // Only the watchdog ends a lost answer
      q = dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0; ifetch <= 1'b0;
      @(posedge clk_i);
   endtask

   // Reset values and an unmapped register place
   task automatic t_regs;
      logic [31:0] q, e [5];
      int l;
      e = '{32'(MODE_RESET), 32'(RD_TIM_RESET), 32'(WR_TIM_RESET), 32'h0, 32'h0};
      for (int i = 0; i < 5; i++) begin
         acc(1'b0, REG_BASE + 32'(4 * i), 4'hF, 32'h0, 1'b0, q, l);
         `CHK("reg", e[i], q)
         `CHK("reg_lat", 2, l)
      end
   endtask

   // Word reads at slow and programmed read timing
   task automatic t_rd32;
      logic [31:0] q;
      int l;
      acc(1'b0, 32'h0A0004, 4'hF, 32'h0, 1'b1, q, l);
      `CHK("rd64k", {8'h3C, 2'h0, fa_f(24'h0A0004, 1'b1)}, q)
      `CHK("fa64k", fa_f(24'h0A0004, 1'b1), la)
      `CHK("width32", MODE_32, req_l.width)
      `CHK("lat_slow", 12, l)
      acc(1'b1, REG_BASE + 32'(OFS_RD_TIMING), 4'hF, 32'h24, 1'b0, q, l);
      acc(1'b1, REG_BASE + 32'(OFS_WR_TIMING), 4'hF, 32'h50, 1'b0, q, l);
      acc(1'b0, 32'h14C004, 4'hF, 32'h0, 1'b0, q, l);
      `CHK("fa8k", fa_f(24'h14C004, 1'b1), la)
      `CHK("lat_fast", 6, l)
   endtask

   // Word writes, refused writes and the sticky flags
   task automatic t_wr32;
      logic [31:0] q;
      int l;
      acc(1'b1, 32'h0A0010, 4'hF, 32'h12345678, 1'b0, q, l);
      `CHK("wdata", 32'h12345678, lw)
      `CHK("fa_wr", fa_f(24'h0A0010, 1'b1), la)
      `CHK("lat_wr", 8, l)
      `CHK("hold_wr", 8'h06, hold)
      acc(1'b1, 32'h0A0014, 4'h3, 32'h0, 1'b0, q, l);
      `CHK("lat_size", 2, l)
      acc(1'b1, 32'h148004, 4'hF, 32'h0BAD0BAD, 1'b0, q, l);
      `CHK("lat_vec", 2, l)
      `CHK("vec_kept", 32'h12345678, lw)
      acc(1'b0, REG_BASE + 32'(OFS_STATUS), 4'hF, 32'h0, 1'b0, q, l);
      `CHK("status", 32'hA, q)
      acc(1'b1, REG_BASE + 32'(OFS_STATUS), 4'hF, 32'hE, 1'b0, q, l);
      acc(1'b0, REG_BASE + 32'(OFS_STATUS), 4'hF, 32'h0, 1'b0, q, l);
      `CHK("st_clr", 32'h0, q)
   endtask

   // Double-word mode: word chosen from the pair, writes refused
   task automatic t_mode64;
      logic [31:0] q;
      int l;
      acc(1'b1, REG_BASE + 32'(OFS_MODE), 4'hF, 32'h2, 1'b0, q, l);
      acc(1'b0, 32'h0A0000, 4'hF, 32'h0, 1'b1, q, l);
      `CHK("hi_word", 8'hA5, q[31:24])
      `CHK("width64", MODE_64, req_l.width)
      `CHK("lat64", 6, l)
      acc(1'b0, 32'h0A0004, 4'hF, 32'h0, 1'b1, q, l);
      `CHK("lo_word", 8'h3C, q[31:24])
      acc(1'b1, 32'h0A0000, 4'hF, 32'h0, 1'b0, q, l);
      `CHK("lat_w64", 2, l)
      acc(1'b0, REG_BASE + 32'(OFS_STATUS), 4'hF, 32'h0, 1'b0, q, l);
      `CHK("st64", 32'h2, q)
      acc(1'b1, REG_BASE + 32'(OFS_STATUS), 4'hF, 32'hE, 1'b0, q, l);
   endtask

   // Half-word mode: lanes, refused fetch, half-word write
   task automatic t_mode16;
      logic [31:0] q;
      int l;
      acc(1'b1, REG_BASE + 32'(OFS_MODE), 4'hF, 32'h0, 1'b0, q, l);
      acc(1'b0, 32'h0A0002, 4'h3, 32'h0, 1'b0, q, l);
      `CHK("half", fa_f(24'h0A0002, 1'b1), {6'h0, q[15:0]} | 22'h360000)
      `CHK("width16", MODE_16, req_l.width)
      acc(1'b0, 32'h0A0000, 4'hC, 32'h0, 1'b1, q, l);
      `CHK("lat_fetch", 2, l)
      acc(1'b0, REG_BASE + 32'(OFS_STATUS), 4'hF, 32'h0, 1'b0, q, l);
      `CHK("st16", 32'h4, q)
      acc(1'b0, 32'h0A0000, 4'hF, 32'h0, 1'b0, q, l);
      `CHK("lat_sel16", 2, l)
      acc(1'b0, 32'h0A0010, 4'hC, 32'h0, 1'b0, q, l);
      `CHK("half_hi", 32'h00080000, q)
      acc(1'b1, 32'h0A0000, 4'hC, 32'hBEEF0000, 1'b0, q, l);
      `CHK("wr16", 16'hBEEF, lw[15:0])
      `CHK("lat_w16", 8, l)
   endtask

   // Smaller variant: interleaved sectors and its capacity
   task automatic t_small;
      logic [31:0] q;
      int l;
      use_small <= 1'b1;
      @(posedge clk_i);
      acc(1'b0, 32'h148000, 4'hF, 32'h0, 1'b0, q, l);
      `CHK("s_even8k", fa_f(24'h148000, 1'b0), la)
      acc(1'b0, 32'h148004, 4'hF, 32'h0, 1'b0, q, l);
      `CHK("s_odd8k", fa_f(24'h148004, 1'b0), la)
      `CHK("s_bit20", 1'b1, la[20])
      acc(1'b0, 32'h0A0004, 4'hF, 32'h0, 1'b0, q, l);
      `CHK("s_64k", {8'h3C, 2'h0, fa_f(24'h0A0004, 1'b0)}, q)
      acc(1'b0, 32'h070000, 4'hF, 32'h0, 1'b0, q, l);
      `CHK("s_absent", 2, l)
      `CHK("s_abs_dat", 32'h0, q)
      acc(1'b0, 32'h100000, 4'hF, 32'h0, 1'b0, q, l);
      `CHK("s_beyond", 2, l)
      acc(1'b1, REG_BASE + 32'(OFS_MODE), 4'hF, 32'h2, 1'b0, q, l);
      acc(1'b0, REG_BASE + 32'(OFS_MODE), 4'hF, 32'h0, 1'b0, q, l);
      `CHK("s_no_wide", 32'(MODE_32), q)
      acc(1'b1, REG_BASE + 32'(OFS_WR_TIMING), 4'hF, 32'hFF, 1'b0, q, l);
      acc(1'b0, REG_BASE + 32'(OFS_WR_TIMING), 4'hF, 32'h0, 1'b0, q, l);
      `CHK("s_wr_tim", 32'hF3, q)
   endtask

   // Verdict and end of run
   task automatic complete_run;
      if (n_errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      clk_i = 1'b0; rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 32'h0;
      sel = 4'h0; wdat = 32'h0; ifetch = 1'b0; use_small = 1'b0;
      n_errors = 0; n_checks = 0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs;
      t_rd32;
      t_wr32;
      t_mode64;
      t_mode16;
      t_small;
      complete_run;
   end

   // Watchdog well beyond the two hundred or so cycles needed
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      complete_run;
   end
endmodule
